// >>> hdl/rtca_consts.svh
// Register offsets, field positions, reset values and timing counts of the alarm block
// Assumes inclusion by bare name from the package and the alarm module
`ifndef RTCA_CONSTS_SVH
`define RTCA_CONSTS_SVH
// Register offsets in the peripheral space
`define RTCA_OFF_ALM_MIN   4'h3
`define RTCA_OFF_ALM_HR    4'h5
`define RTCA_OFF_ALM_DAY   4'h7
`define RTCA_OFF_FORCE     4'h8
`define RTCA_OFF_OSC       4'h9
`define RTCA_OFF_CMD       4'hb
`define RTCA_OFF_WD_LO     4'hc
`define RTCA_OFF_WD_HI     4'hd
// Command register bit positions
`define RTCA_CMD_TE        7
`define RTCA_CMD_ALARM_ROUTING_SELECT      6
`define RTCA_CMD_IBHL      5
`define RTCA_CMD_PULV      4
`define RTCA_CMD_WAM       3
`define RTCA_CMD_TDM       2
`define RTCA_CMD_WAF       1
`define RTCA_CMD_TDF       0
// Mask bit of each alarm register, force bit, oscillator disable bit
`define RTCA_ALM_MASK      7
`define RTCA_FORCE_BIT     0
`define RTCA_OSC_DIS       7
// Reset values
`define RTCA_RST_ALM       8'h80
`define RTCA_RST_CMD       6'h03
`define RTCA_RST_OSC       8'h80
`define RTCA_RST_FORCE     8'h00
`define RTCA_RST_WD        8'h00
// Timing: interrupt pulse width in ms, clock rate in Hz, derived cycle count
`define RTCA_PULSE_MS      3
`define RTCA_CLK_HZ        20000000
`define RTCA_PULSE_CYC     ((`RTCA_PULSE_MS * `RTCA_CLK_HZ) / 1000)
`endif

// >>> hdl/rtca_pkg.sv
// Types shared by the alarm block
// Assumes the constants header sits beside it
package rtca_pkg;
    `include "rtca_consts.svh"
    // Complete state of the alarm block
    typedef struct packed {
        logic [7:0]  alm_min;    // Minutes alarm, mask in bit 7
        logic [7:0]  alm_hr;     // Hours alarm
        logic [7:0]  alm_day;    // Days alarm
        logic [7:0]  force_r;    // Combined line force control
        logic [7:0]  osc;        // Oscillator control
        logic [5:0]  cmd;        // Command bits 7..2
        logic        wdf;        // Watchdog alarm flag
        logic        tod_alarm_flag;        // Time-of-day alarm flag
        logic [7:0]  wd_lo;      // Interval low byte
        logic [7:0]  wd_hi;      // Interval high byte
        logic [15:0] wd_cnt;     // Interval down counter
        logic        act_a_d;    // Previous primary activation
        logic        act_b_d;    // Previous secondary activation
        logic [15:0] pcnt_a;     // Primary pulse timer
        logic [15:0] pcnt_b;     // Secondary pulse timer
        logic        pri_n;      // Primary line, active low
        logic        sec;        // Secondary line level
        logic        od_oe;      // Combined line pull-down enable
        logic [7:0]  rdata;      // Read data
        logic        vcc_s1;     // Power-good sync stage 1
        logic        vcc_s2;     // Power-good sync stage 2
    } rtca_state_t;
endpackage : rtca_pkg

// >>> hdl/rtca_alarm.sv
// Alarm and interrupt logic of a real-time clock: time-of-day and watchdog alarms
// Assumes time values and ticks come from timekeeping logic on sys_clk; vcc_ok is a pin

`include "rtca_consts.svh"

module rtca_alarm
    import rtca_pkg::*;
#(
    parameter int PULSE_CYCLES = `RTCA_PULSE_CYC      // Interrupt pulse width in cycles
)(
    input  wire logic       sys_clk,                // System clock, 20 MHz
    input  wire logic       srst,                   // Synchronous reset, first power-up
    input  wire logic [3:0] bus_addr,               // Register offset
    input  wire logic [7:0] bus_wdata,              // Write data
    input  wire logic       bus_wr,                 // Write strobe, one cycle
    input  wire logic       bus_rd,                 // Read strobe, one cycle
    output logic      [7:0] bus_rdata,              // Read data, valid cycle after bus_rd
    input  wire logic [6:0] cur_minutes,            // Current minutes
    input  wire logic [6:0] cur_hours,              // Current hours
    input  wire logic [6:0] cur_days,               // Current day
    input  wire logic       minute_tick,            // Pulse at each new minute
    input  wire logic       hundredth_tick,         // Pulse each 0.01 s
    input  wire logic       vcc_ok,                 // Main power present, asynchronous
    output logic            primary_alarm_line_n,   // Primary alarm line, active low
    output logic            secondary_alarm_line,   // Secondary alarm line, polarity by command
    output logic            combined_od_out,        // Combined line output value, always low
    output logic            combined_od_oe,         // Combined line pull-down enable
    output logic            time_update_enable,     // Time register updates enabled
    output logic            oscillator_run          // Timekeeping oscillator running
);

    localparam logic [15:0] PULSE_LEN = 16'(PULSE_CYCLES);

    rtca_state_t s_r;
    rtca_state_t s_nxt;

    logic       pwr;        // Synchronised main power
    logic       wr_ok;
    logic       rd_ok;
    logic       acc_wd;     // Access to an interval register
    logic       acc_tod;    // Access to an alarm register
    logic       tod_match;
    logic       tod_set;
    logic       wd_set;
    logic       osc_on;
    logic       en_tod;
    logic       en_wd;
    logic       src_a;
    logic       src_b;
    logic       act_a;
    logic       act_b;
    logic       line_a;
    logic       line_b;
    logic [15:0] wd_load;

    // Bus qualification: host accesses only land while main power is present
    // Flags set during power loss therefore survive until power returns
    assign pwr     = s_r.vcc_s2;
    assign wr_ok   = bus_wr & pwr;
    assign rd_ok   = bus_rd & pwr;
    assign acc_wd  = (wr_ok | rd_ok) &
                     (bus_addr == `RTCA_OFF_WD_LO || bus_addr == `RTCA_OFF_WD_HI);
    assign acc_tod = (wr_ok | rd_ok) & (bus_addr == `RTCA_OFF_ALM_MIN ||
                     bus_addr == `RTCA_OFF_ALM_HR || bus_addr == `RTCA_OFF_ALM_DAY);
    // oscillator runs while disable bit is zero
    assign osc_on  = ~s_r.osc[`RTCA_OSC_DIS];
    assign wd_load = {s_r.wd_hi, s_r.wd_lo};

    assign tod_match = (s_r.alm_min[`RTCA_ALM_MASK] | (s_r.alm_min[6:0] == cur_minutes)) &
                       (s_r.alm_hr[`RTCA_ALM_MASK]  | (s_r.alm_hr[6:0]  == cur_hours))   &
                       (s_r.alm_day[`RTCA_ALM_MASK] | (s_r.alm_day[6:0] == cur_days));
    // Match is judged only at the tick, so one minute sets the flag once
    // alarm evaluated regardless of main power
    assign tod_set = minute_tick & osc_on & tod_match;
    // A zero interval parks the watchdog so it never times out
    // watchdog time-out when the counter expires
    assign wd_set  = hundredth_tick & osc_on & (wd_load != 16'h0000) & (s_r.wd_cnt <= 16'h0001);

    // interrupt enables from the mask bits
    assign en_wd   = ~s_r.cmd[`RTCA_CMD_WAM - 2];
    assign en_tod  = ~s_r.cmd[`RTCA_CMD_TDM - 2];
    // routing: the secondary line carries the other alarm
    assign src_a   = s_r.cmd[`RTCA_CMD_ALARM_ROUTING_SELECT - 2] ? (s_r.tod_alarm_flag & en_tod) : (s_r.wdf & en_wd);
    assign src_b   = s_r.cmd[`RTCA_CMD_ALARM_ROUTING_SELECT - 2] ? (s_r.wdf & en_wd) : (s_r.tod_alarm_flag & en_tod);
    assign act_a   = src_a;
    assign act_b   = src_b;
    // level output follows flag and enable
    assign line_a  = s_r.cmd[`RTCA_CMD_PULV - 2] ? (s_r.pcnt_a != 16'h0000) : act_a;
    assign line_b  = s_r.cmd[`RTCA_CMD_PULV - 2] ? (s_r.pcnt_b != 16'h0000) : act_b;

    // Next-state logic
    always_comb
    begin
        s_nxt = s_r;
        // Power-good synchroniser
        s_nxt.vcc_s1 = vcc_ok;
        s_nxt.vcc_s2 = s_r.vcc_s1;

        // Register writes
        if (wr_ok)
        begin
            case (bus_addr)
                `RTCA_OFF_ALM_MIN: s_nxt.alm_min = bus_wdata;
                `RTCA_OFF_ALM_HR:  s_nxt.alm_hr  = bus_wdata;
                `RTCA_OFF_ALM_DAY: s_nxt.alm_day = bus_wdata;
                `RTCA_OFF_FORCE:   s_nxt.force_r = bus_wdata;
                `RTCA_OFF_OSC:     s_nxt.osc     = bus_wdata;
                // command write, flag bits are not writable
                `RTCA_OFF_CMD:     s_nxt.cmd     = bus_wdata[7:2];
                `RTCA_OFF_WD_LO:   s_nxt.wd_lo   = bus_wdata;
                `RTCA_OFF_WD_HI:   s_nxt.wd_hi   = bus_wdata;
                default:           s_nxt.cmd     = s_r.cmd;
            endcase
        end

        // Read data, unmapped offsets read zero
        s_nxt.rdata = s_r.rdata;
        if (rd_ok)
        begin
            case (bus_addr)
                `RTCA_OFF_ALM_MIN: s_nxt.rdata = s_r.alm_min;
                `RTCA_OFF_ALM_HR:  s_nxt.rdata = s_r.alm_hr;
                `RTCA_OFF_ALM_DAY: s_nxt.rdata = s_r.alm_day;
                `RTCA_OFF_FORCE:   s_nxt.rdata = s_r.force_r;
                `RTCA_OFF_OSC:     s_nxt.rdata = s_r.osc;
                `RTCA_OFF_CMD:     s_nxt.rdata = {s_r.cmd, s_r.wdf, s_r.tod_alarm_flag};
                `RTCA_OFF_WD_LO:   s_nxt.rdata = s_r.wd_lo;
                `RTCA_OFF_WD_HI:   s_nxt.rdata = s_r.wd_hi;
                default:           s_nxt.rdata = 8'h00;
            endcase
        end

        // Watchdog counter: reload on interval write, count on ticks
        if (wr_ok && (bus_addr == `RTCA_OFF_WD_LO || bus_addr == `RTCA_OFF_WD_HI))
        begin
            s_nxt.wd_cnt = (bus_addr == `RTCA_OFF_WD_LO) ? {s_r.wd_hi, bus_wdata}
                                                          : {bus_wdata, s_r.wd_lo};
        end
        else if (wd_set)
        begin
            s_nxt.wd_cnt = wd_load;
        end
        else if (hundredth_tick && osc_on && wd_load != 16'h0000)
        begin
            s_nxt.wd_cnt = s_r.wd_cnt - 16'h0001;
        end

        // watchdog flag, a time-out wins over a clearing access
        // flags change only by events and accesses
        if (wd_set)
            s_nxt.wdf = 1'b1;
        else if (acc_wd)
            s_nxt.wdf = 1'b0;

        // time-of-day flag, a match wins over a clearing access
        if (tod_set)
            s_nxt.tod_alarm_flag = 1'b1;
        else if (acc_tod)
            s_nxt.tod_alarm_flag = 1'b0;

        // A standing flag gives one pulse, not a train
        // pulse timers start on a new activation
        s_nxt.act_a_d = act_a;
        s_nxt.act_b_d = act_b;
        if (act_a && !s_r.act_a_d)
            s_nxt.pcnt_a = PULSE_LEN;
        else if (s_r.pcnt_a != 16'h0000)
            s_nxt.pcnt_a = s_r.pcnt_a - 16'h0001;
        if (act_b && !s_r.act_b_d)
            s_nxt.pcnt_b = PULSE_LEN;
        else if (s_r.pcnt_b != 16'h0000)
            s_nxt.pcnt_b = s_r.pcnt_b - 16'h0001;

        s_nxt.pri_n = ~line_a;
        s_nxt.sec   = s_r.cmd[`RTCA_CMD_IBHL - 2] ? line_b : ~line_b;
        // combined line tracks primary or force bit
        s_nxt.od_oe = line_a | s_r.force_r[`RTCA_FORCE_BIT];
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            // first power-up: state taken to a defined value
            s_r         <= '0;
            s_r.alm_min <= `RTCA_RST_ALM;
            s_r.alm_hr  <= `RTCA_RST_ALM;
            s_r.alm_day <= `RTCA_RST_ALM;
            s_r.force_r <= `RTCA_RST_FORCE;
            s_r.osc     <= `RTCA_RST_OSC;
            s_r.cmd     <= `RTCA_RST_CMD;
            s_r.wd_lo   <= `RTCA_RST_WD;
            s_r.wd_hi   <= `RTCA_RST_WD;
            s_r.pri_n   <= 1'b1;
            s_r.sec     <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register, except the combined line value, which is tied low
    assign bus_rdata            = s_r.rdata;
    assign primary_alarm_line_n = s_r.pri_n;
    assign secondary_alarm_line = s_r.sec;
    assign combined_od_out      = 1'b0;
    assign combined_od_oe       = s_r.od_oe;
    assign time_update_enable   = s_r.cmd[`RTCA_CMD_TE - 2];
    assign oscillator_run       = ~s_r.osc[`RTCA_OSC_DIS];

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_wd_flag_set: assert property (wd_set |=> s_r.wdf)
        else $error("watchdog flag not set on time-out");

    // interval write clears flag unless a time-out coincides
    a_wd_write_clr: assert property (wr_ok && bus_addr == `RTCA_OFF_WD_LO && !wd_set |=> !s_r.wdf)
        else $error("interval write did not clear watchdog flag");

    // alarm write clears the flag unless a match coincides
    a_tod_write_clr: assert property (wr_ok && bus_addr == `RTCA_OFF_ALM_MIN && !tod_set |=> !s_r.tod_alarm_flag)
        else $error("alarm write did not clear time-of-day flag");

    // all masked gives an alarm at every running minute
    a_tod_every_min: assert property (minute_tick && osc_on && s_r.alm_min[7] && s_r.alm_hr[7]
                                      && s_r.alm_day[7] |=> s_r.tod_alarm_flag)
        else $error("masked alarm missed a minute");

    a_tod_no_match: assert property (minute_tick && !s_r.alm_min[7] && s_r.alm_min[6:0] != cur_minutes
                                     && !acc_tod && !s_r.tod_alarm_flag |=> !s_r.tod_alarm_flag)
        else $error("alarm raised without a minutes match");

    // flag holds without event or access
    a_flag_hold: assert property (!tod_set && !acc_tod |=> s_r.tod_alarm_flag == $past(s_r.tod_alarm_flag))
        else $error("time-of-day flag changed on its own");

    // level mode follows the routed source one cycle on
    a_level_follow: assert property (!s_r.cmd[2] && !$past(s_r.cmd[2]) |=> s_r.pri_n == !$past(act_a))
        else $error("primary level does not follow its alarm");

    // combined line follows primary and force bit
    a_comb_track: assert property (##1 s_r.od_oe == ($past(line_a) | $past(s_r.force_r[0])))
        else $error("combined line does not track primary");

    // both lines active together in level mode only if both alarms are
    a_route_compl: assert property (!s_r.cmd[2] && !s_r.cmd[3] && s_r.wdf && !s_r.tod_alarm_flag && en_wd
                                    |-> act_a != act_b)
        else $error("lines are not complementary");

    // a new activation in pulse mode loads the pulse timer with the pulse width
    a_pulse_len: assert property (s_r.cmd[2] && act_a && !s_r.act_a_d |=> s_r.pcnt_a == PULSE_LEN)
        else $error("pulse timer not loaded with pulse width");

    // masked watchdog never drives a line
    a_wd_masked: assert property (!en_wd && !s_r.tod_alarm_flag |-> !act_a && !act_b)
        else $error("masked watchdog reached an output");

    // reading the high interval byte clears the watchdog flag
    a_wd_read_clr: assert property (rd_ok && bus_addr == `RTCA_OFF_WD_HI && !wd_set |=> !s_r.wdf)
        else $error("interval read did not clear watchdog flag");

    // reading an alarm register clears the time-of-day flag
    a_tod_read_clr: assert property (rd_ok && bus_addr == `RTCA_OFF_ALM_HR && !tod_set |=> !s_r.tod_alarm_flag)
        else $error("alarm read did not clear time-of-day flag");

    // quiet command value masks both alarms, updates stay on
    a_cmd_quiet: assert property (wr_ok && bus_addr == `RTCA_OFF_CMD && bus_wdata == 8'h8c |=>
                                  !en_wd && !en_tod && s_r.cmd[`RTCA_CMD_TE - 2])
        else $error("quiet command left an alarm enabled");

    // zero force value stops forcing the combined line
    a_force_off: assert property (wr_ok && bus_addr == `RTCA_OFF_FORCE && bus_wdata == 8'h00 |=>
                                  !s_r.force_r[`RTCA_FORCE_BIT])
        else $error("force bit still set after zero write");

    // oscillator value keeps the oscillator running
    a_osc_keep: assert property (wr_ok && bus_addr == `RTCA_OFF_OSC && bus_wdata == 8'h40 |=> osc_on)
        else $error("oscillator stopped after run value");

    // secondary level follows its source and polarity bit
    a_sec_follow: assert property (!s_r.cmd[2] |=>
                                   s_r.sec == ($past(s_r.cmd[3]) ? $past(act_b) : !$past(act_b)))
        else $error("secondary level does not follow its alarm");

    // a time-out reloads the interval counter
    a_wd_reload: assert property (wd_set && !wr_ok |=> s_r.wd_cnt == $past(wd_load))
        else $error("interval counter not reloaded on time-out");

    // no access reaches the flag while power is absent
    a_tdf_keep_off: assert property (!pwr && s_r.tod_alarm_flag |=> s_r.tod_alarm_flag)
        else $error("time-of-day flag lost during power loss");

    // watchdog flag holds without event or access
    a_wdf_hold: assert property (!wd_set && !acc_wd |=> s_r.wdf == $past(s_r.wdf))
        else $error("watchdog flag changed on its own");

    // pulse timer counts down one per cycle
    a_pulse_count: assert property (s_r.pcnt_a != 16'h0000 && !(act_a && !s_r.act_a_d) |=>
                                    s_r.pcnt_a == $past(s_r.pcnt_a) - 16'h0001)
        else $error("pulse timer did not count down");

    c_tod_alarm: cover property (tod_set ##1 s_r.tod_alarm_flag ##[1:4] !s_r.tod_alarm_flag);
    c_wd_alarm: cover property (wd_set ##1 s_r.wdf);
    c_pulse_end: cover property (s_r.pcnt_a == 16'h0001 ##1 s_r.pcnt_a == 16'h0000);
    c_power_loss: cover property (!pwr && tod_set);
    c_route_swap: cover property (!s_r.cmd[4] && s_r.wdf && en_wd ##1 !primary_alarm_line_n);

endmodule : rtca_alarm

// >>> test/rtca_host_model.sv
// Host side of the combined interrupt line: pull-up resolution and an interrupt edge counter
// Assumes the block only ever enables a pull-down on the combined line
module rtca_host_model (
    input  wire logic       sys_clk,      // System clock
    input  wire logic       od_out,       // Combined line drive value
    input  wire logic       od_oe,        // Combined line pull-down enable
    input  wire logic       irq_enable,   // Host interrupts enabled
    output logic            host_irq_n,   // Host external interrupt input level
    output logic [7:0]      irq_count     // Falling edges seen while enabled
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev_r;
    // pull-up keeps the line high unless pulled low
    assign host_irq_n = od_oe ? od_out : 1'b1;
    // Start with no events and an idle line
    initial
    begin
        irq_count = 8'h00;
        prev_r = 1'b1;
    end
    // edges count only after software enables interrupts
    always @(posedge sys_clk)
    begin
        if (irq_enable && prev_r && !host_irq_n)
            irq_count <= irq_count + 8'h01;
        prev_r <= host_irq_n;
    end
endmodule : rtca_host_model

// >>> test/rtca_alarm_bench.sv
// Self-checking bench of the alarm block: registers, mask patterns, watchdog, power loss, pulse, force
// Assumes rtca_alarm with a pulse width of 8 cycles and the host model on the combined line
module rtca_alarm_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PULSE_LEN = 8;
    logic       sys_clk, srst, bus_wr, bus_rd, minute_tick, hundredth_tick, vcc_ok, irq_enable;
    logic [3:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, irq_count;
    logic [6:0] cur_minutes, cur_hours, cur_days;
    logic       primary_alarm_line_n, secondary_alarm_line, combined_od_out, combined_od_oe;
    logic       time_update_enable, oscillator_run, host_irq_n;
    int         errors, comparisons;
    rtca_alarm #(.PULSE_CYCLES(PULSE_LEN)) uut (.sys_clk(sys_clk), .srst(srst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .cur_minutes(cur_minutes), .cur_hours(cur_hours), .cur_days(cur_days), .minute_tick(minute_tick),
        .hundredth_tick(hundredth_tick), .vcc_ok(vcc_ok), .primary_alarm_line_n(primary_alarm_line_n),
        .secondary_alarm_line(secondary_alarm_line), .combined_od_out(combined_od_out),
        .combined_od_oe(combined_od_oe), .time_update_enable(time_update_enable),
        .oscillator_run(oscillator_run));
    rtca_host_model host (.sys_clk(sys_clk), .od_out(combined_od_out), .od_oe(combined_od_oe),
        .irq_enable(irq_enable), .host_irq_n(host_irq_n), .irq_count(irq_count));
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] expd, input string what);
        comparisons++;
        if (seen !== expd)
        begin
            errors++;
            $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, expd);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1 bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(posedge sys_clk);
        #1 bus_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1 bus_addr = a;
        bus_rd = 1'b1;
        @(posedge sys_clk);
        #1 bus_rd = 1'b0;
        d = bus_rdata;
    endtask : rd
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        check(d, e, "register read");
    endtask : rdchk
    // One-cycle tick, minute or hundredth
    task automatic tick(input logic hun);
        @(posedge sys_clk);
        #1 {hundredth_tick, minute_tick} = hun ? 2'b10 : 2'b01;
        @(posedge sys_clk);
        #1 {hundredth_tick, minute_tick} = 2'b00;
    endtask : tick
    task automatic test_reset;
        logic [3:0] offs [9] = '{4'h3, 4'h5, 4'h7, 4'h8, 4'h9, 4'hb, 4'hc, 4'hd, 4'h0};
        logic [7:0] vals [9] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h80, 8'h0c, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 9; i++)
            rdchk(offs[i], vals[i]);
        check({4'h0, primary_alarm_line_n, secondary_alarm_line, combined_od_oe, time_update_enable}, 8'h0c, "idle");
        $display("test_reset done");
    endtask : test_reset
    task automatic test_init;
        wr(4'hb, 8'h8c);
        wr(4'h9, 8'h40);
        wr(4'h8, 8'h00);
        cyc(3);
        rdchk(4'hb, 8'h8c);
        rdchk(4'h9, 8'h40);
        check({6'h0, time_update_enable, oscillator_run}, 8'h03, "time and oscillator");
        // host interrupts only after the alarm state is set up
        irq_enable = 1'b1;
        $display("test_init done");
    endtask : test_init
    task automatic test_tod;
        logic [2:0] mk;
        logic       hit;
        wr(4'hb, 8'hc8);
        // only the four legal mask patterns
        for (int m = 0; m < 4; m++)
        begin
            mk = 3'b111 << m;
            wr(4'h3, {mk[0], 7'h15});
            wr(4'h5, {mk[1], 7'h0a});
            wr(4'h7, {mk[2], 7'h03});
            for (int f = 0; f < 4; f++)
            begin
                cur_minutes = 7'h15 ^ {6'h0, f == 0};
                cur_hours = 7'h0a ^ {6'h0, f == 1};
                cur_days = 7'h03 ^ {6'h0, f == 2};
                hit = (f == 3) || mk[f];
                tick(1'b0);
                cyc(2);
                check({5'h0, primary_alarm_line_n, combined_od_oe, host_irq_n}, {5'h0, !hit, hit, !hit}, "tod");
                check({7'h0, secondary_alarm_line}, 8'h01, "other line idle");
                wr(4'h3, {mk[0], 7'h15});
                cyc(2);
                check({7'h0, primary_alarm_line_n}, 8'h01, "tod cleared");
            end
        end
        $display("test_tod done");
    endtask : test_tod
    task automatic test_wd;
        logic [7:0] d;
        wr(4'hb, 8'hc4);
        wr(4'hd, 8'h00);
        wr(4'hc, 8'h03);
        repeat (2) tick(1'b1);
        cyc(2);
        check({7'h0, secondary_alarm_line}, 8'h01, "wd early");
        tick(1'b1);
        cyc(2);
        check({6'h0, secondary_alarm_line, primary_alarm_line_n}, 8'h01, "wd timeout");
        rd(4'hc, d);
        cyc(2);
        check({7'h0, secondary_alarm_line}, 8'h01, "wd read clear");
        wr(4'hb, 8'hcc);
        repeat (3) tick(1'b1);
        cyc(2);
        check({7'h0, secondary_alarm_line}, 8'h01, "wd masked");
        rdchk(4'hb, 8'hce);
        wr(4'hc, 8'h00);
        rdchk(4'hb, 8'hcc);
        // swapped routing: watchdog on primary, secondary active high
        wr(4'hb, 8'ha4);
        wr(4'hc, 8'h03);
        repeat (3) tick(1'b1);
        cyc(2);
        check({6'h0, secondary_alarm_line, primary_alarm_line_n}, 8'h00, "wd on primary");
        wr(4'hc, 8'h00);
        cyc(2);
        check({7'h0, primary_alarm_line_n}, 8'h01, "wd primary clear");
        $display("test_wd done");
    endtask : test_wd
    task automatic test_power_pulse;
        logic [7:0] d, n, n0;
        wr(4'hb, 8'hc8);
        wr(4'h3, 8'h80);
        wr(4'h5, 8'h80);
        wr(4'h7, 8'h80);
        vcc_ok = 1'b0;
        cyc(3);
        tick(1'b0);
        wr(4'h3, 8'h80);
        cyc(2);
        check({7'h0, primary_alarm_line_n}, 8'h00, "alarm without power");
        vcc_ok = 1'b1;
        cyc(3);
        check({7'h0, primary_alarm_line_n}, 8'h00, "alarm after power");
        rd(4'h5, d);
        cyc(2);
        check({7'h0, primary_alarm_line_n}, 8'h01, "read clear");
        wr(4'hb, 8'hd8);
        n0 = irq_count;
        n = 8'h00;
        tick(1'b0);
        repeat (20)
        begin
            cyc(1);
            n = n + {7'h0, !primary_alarm_line_n};
        end
        check(n, 8'(PULSE_LEN), "pulse width");
        check(irq_count - n0, 8'h01, "host edges");
        wr(4'h8, 8'h01);
        cyc(2);
        check({6'h0, combined_od_oe, host_irq_n}, 8'h02, "forced");
        wr(4'h8, 8'h00);
        cyc(2);
        check({6'h0, combined_od_oe, host_irq_n}, 8'h01, "force off");
        $display("test_power_pulse done");
    endtask : test_power_pulse
    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // Clock
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Watchdog against a hang
    initial
    begin
        #200000;
        errors++;
        tally_and_finish();
    end
    // Main sequence
    initial
    begin
        {srst, vcc_ok} = 2'b11;
        {bus_wr, bus_rd, minute_tick, hundredth_tick, irq_enable} = 5'h00;
        {bus_addr, bus_wdata} = 12'h000;
        {cur_minutes, cur_hours, cur_days} = 21'h0;
        repeat (2) @(posedge sys_clk);
        #1 srst = 1'b0;
        cyc(3);
        test_reset();
        test_init();
        test_tod();
        test_wd();
        test_power_pulse();
        tally_and_finish();
    end
endmodule : rtca_alarm_bench
